// ### shared/serial_output_pkg.sv
package serial_output_pkg;
    // geometry
    localparam int          NUM_CH        = 8;
    localparam int          SAMPLE_W      = 12;
    localparam int          ADDR_W        = 15;
    localparam int          DATA_W        = 8;
    localparam int          PHASE_W       = 4;
    localparam int          NUM_PHASES    = 11;
    // serial control frame: rw bit, address, data
    localparam int          FRAME_BITS    = 24;
    localparam int          HDR_BITS      = 16;
    localparam logic [4:0]  CNT_RW        = 5'h00;
    localparam logic [4:0]  CNT_ADDR_LAST = 5'h0F;
    localparam logic [4:0]  CNT_HDR_DONE  = 5'h10;
    localparam logic [4:0]  CNT_LAST      = 5'h17;
    localparam logic [4:0]  CNT_ONE       = 5'h01;
    // register offsets
    localparam logic [ADDR_W-1:0] CH_SELECT_ADDR  = 15'h0005;
    localparam logic [ADDR_W-1:0] OUT_FORMAT_ADDR = 15'h0014;
    localparam logic [ADDR_W-1:0] OUT_ADJUST_ADDR = 15'h0015;
    localparam logic [ADDR_W-1:0] OUT_PHASE_ADDR  = 15'h0016;
    // reset values
    localparam logic [7:0]  CH_SELECT_RST  = 8'hFF;
    localparam logic [7:0]  FORMAT_RST     = 8'h00;
    localparam logic [7:0]  ADJUST_RST     = 8'h00;
    localparam logic [PHASE_W-1:0] PHASE_RST = 4'h3;
    // fields
    localparam logic [7:0]  FORMAT_SHARED_MASK = 8'hFB;
    localparam logic [7:0]  ADJUST_SHARED_MASK = 8'hFE;
    localparam int          INVERT_BIT     = 2;
    localparam int          DRIVE_X2_BIT   = 0;
    localparam int          FMT_LSB        = 0;
    localparam logic [1:0]  FMT_OFFSET_BIN = 2'h0;
    localparam logic [1:0]  FMT_TWOS       = 2'h1;
    localparam logic [PHASE_W-1:0] PHASE_MAX = 4'hA;
    localparam int          DEG_PER_STEP   = 60;
endpackage : serial_output_pkg

// ### hw/serial_port_slave.sv
module serial_port_slave
    import serial_output_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              arst_n_in,
    // serial control pins
    input  wire logic              csb_n_in,
    input  wire logic              sclk_in,
    input  wire logic              sdio_in,
    output logic                   sdio_out,
    output logic                   sdio_oe_out,
    // register side
    input  wire logic [DATA_W-1:0] rd_data_in,
    output logic [ADDR_W-1:0]      addr_out,
    output logic [DATA_W-1:0]      wr_data_out,
    output logic                   wr_en_out
);
    typedef struct packed {
        logic              sclk;
        logic [4:0]        cnt;
        logic              rd;
        logic [ADDR_W-1:0] shift;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              sdo;
        logic              oe;
        logic              wr;
        logic [DATA_W-1:0] wdata;
    } port_state_t;

    port_state_t s_q;
    port_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.sclk = sclk_in;
        s_d.wr   = 1'b0;
        if (csb_n_in) begin
            s_d.cnt = CNT_RW;
            s_d.rd  = 1'b0;
            s_d.oe  = 1'b0;
        end else if (sclk_in && !s_q.sclk) begin
            s_d.shift = {s_q.shift[ADDR_W-2:0], sdio_in};
            s_d.cnt   = s_q.cnt + CNT_ONE;
            if (s_q.cnt == CNT_RW)
                s_d.rd = sdio_in;
            if (s_q.cnt == CNT_ADDR_LAST)
                s_d.addr = {s_q.shift[ADDR_W-2:0], sdio_in};
            if (s_q.cnt == CNT_LAST && !s_q.rd) begin
                s_d.wr    = 1'b1;
                s_d.wdata = {s_q.shift[DATA_W-2:0], sdio_in};
            end
        end else if (!sclk_in && s_q.sclk && s_q.rd
                     && s_q.cnt >= CNT_HDR_DONE) begin
            // first falling edge after the header loads the answer
            if (s_q.cnt == CNT_HDR_DONE) begin
                s_d.sdo  = rd_data_in[DATA_W-1];
                s_d.dout = {rd_data_in[DATA_W-2:0], 1'b0};
                // drive from the moment the msb is on the pin
                s_d.oe   = 1'b1;
            end else begin
                s_d.sdo  = s_q.dout[DATA_W-1];
                s_d.dout = {s_q.dout[DATA_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign addr_out    = s_q.addr;
    assign wr_data_out = s_q.wdata;
    assign wr_en_out   = s_q.wr;
    assign sdio_out    = s_q.sdo;
    assign sdio_oe_out = s_q.oe && !csb_n_in;
endmodule : serial_port_slave

// ### hw/serial_output_config_regs.sv
module serial_output_config_regs
    import serial_output_pkg::*;
#(
    parameter int CH = NUM_CH,
    parameter int SW = SAMPLE_W
) (
    // clock and reset
    input  wire logic                     core_clk_in,
    input  wire logic                     arst_n_in,
    // serial control port
    input  wire logic                     csb_n_in,
    input  wire logic                     sclk_in,
    input  wire logic                     sdio_in,
    output logic                          sdio_out,
    output logic                          sdio_oe_out,
    // converter samples and divider phases
    input  wire logic [CH-1:0][SW-1:0]    sample_in,
    input  wire logic                     sample_valid_in,
    input  wire logic [NUM_PHASES-1:0]    divider_phase_in,
    input  wire logic                     frame_clk_in,
    // serial link side
    output logic [CH-1:0][SW-1:0]         sample_out,
    output logic                          serial_bit_clock_out,
    output logic                          serial_frame_clock_out,
    output logic [CH-1:0]                 drive_x2_out,
    output logic [7:0]                    format_shared_out,
    output logic [7:0]                    adjust_shared_out
);
    typedef struct packed {
        logic [7:0]             ch_sel;
        logic [7:0]             fmt;
        logic [CH-1:0]          inv;
        logic [7:0]             adj;
        logic [CH-1:0]          drv;
        logic [PHASE_W-1:0]     phase;
        logic [CH-1:0][SW-1:0]  smp;
        logic                   bclk;
        logic                   fclk;
    } cfg_state_t;

    cfg_state_t s_q;
    cfg_state_t s_d;

    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wr_data;
    logic                  wr_en;
    logic [DATA_W-1:0]     rd_data;
    logic [CH-1:0][SW-1:0] enc;
    logic [CH-1:0]         sel;

    serial_port_slave u_port (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .csb_n_in    (csb_n_in),
        .sclk_in     (sclk_in),
        .sdio_in     (sdio_in),
        .sdio_out    (sdio_out),
        .sdio_oe_out (sdio_oe_out),
        .rd_data_in  (rd_data),
        .addr_out    (addr),
        .wr_data_out (wr_data),
        .wr_en_out   (wr_en)
    );

    assign sel = s_q.ch_sel[CH-1:0];

    // per-channel encode; only the sample strobe times the capture
    for (genvar c = 0; c < CH; c++) begin : g_enc
        logic [SW-1:0] coded;
        always_comb begin
            coded = sample_in[c];
            if (s_q.fmt[FMT_LSB +: 2] == FMT_TWOS)
                coded[SW-1] = ~sample_in[c][SW-1];
            enc[c] = s_q.inv[c] ? ~coded : coded;
        end
    end

    // readback shows the per-channel bit of the lowest selected channel
    always_comb begin
        logic inv_rb;
        logic drv_rb;
        logic found;
        inv_rb = 1'b0;
        drv_rb = 1'b0;
        found  = 1'b0;
        for (int c = 0; c < CH; c++) begin
            if (sel[c] && !found) begin
                inv_rb = s_q.inv[c];
                drv_rb = s_q.drv[c];
                found  = 1'b1;
            end
        end
        case (addr)
            CH_SELECT_ADDR:  rd_data = s_q.ch_sel;
            OUT_FORMAT_ADDR:
                rd_data = s_q.fmt | (DATA_W'(inv_rb) << INVERT_BIT);
            OUT_ADJUST_ADDR:
                rd_data = s_q.adj | (DATA_W'(drv_rb) << DRIVE_X2_BIT);
            OUT_PHASE_ADDR:  rd_data = {{(DATA_W-PHASE_W){1'b0}}, s_q.phase};
            default:         rd_data = 8'h00;
        endcase
    end

    always_comb begin
        s_d      = s_q;
        s_d.fclk = frame_clk_in;
        s_d.bclk = divider_phase_in[s_q.phase];
        if (sample_valid_in)
            s_d.smp = enc;
        if (wr_en) begin
            case (addr)
                CH_SELECT_ADDR: s_d.ch_sel = wr_data;
                OUT_FORMAT_ADDR: begin
                    s_d.fmt = wr_data & FORMAT_SHARED_MASK;
                    for (int c = 0; c < CH; c++)
                        if (sel[c])
                            s_d.inv[c] = wr_data[INVERT_BIT];
                end
                OUT_ADJUST_ADDR: begin
                    s_d.adj = wr_data & ADJUST_SHARED_MASK;
                    for (int c = 0; c < CH; c++)
                        if (sel[c])
                            s_d.drv[c] = wr_data[DRIVE_X2_BIT];
                end
                OUT_PHASE_ADDR: begin
                    if (wr_data[PHASE_W-1:0] <= PHASE_MAX)
                        s_d.phase = wr_data[PHASE_W-1:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q        <= '0;
            s_q.ch_sel <= CH_SELECT_RST;
            s_q.fmt    <= FORMAT_RST;
            s_q.adj    <= ADJUST_RST;
            s_q.phase  <= PHASE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sample_out             = s_q.smp;
    assign serial_bit_clock_out   = s_q.bclk;
    assign serial_frame_clock_out = s_q.fclk;
    assign drive_x2_out           = s_q.drv;
    assign format_shared_out      = s_q.fmt;
    assign adjust_shared_out      = s_q.adj;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    offset_binary_a: assert property (
        sample_valid_in && s_q.fmt[1:0] == FMT_OFFSET_BIN && !s_q.inv[0]
        |=> sample_out[0] == $past(sample_in[0]))
        else $error("offset binary sample altered");
    twos_comp_a: assert property (
        sample_valid_in && s_q.fmt[1:0] == FMT_TWOS && !s_q.inv[0]
        |=> sample_out[0] == {~$past(sample_in[0][SW-1]),
                              $past(sample_in[0][SW-2:0])})
        else $error("twos complement msb not flipped");
    invert_local_a: assert property (
        wr_en && addr == OUT_FORMAT_ADDR && !sel[0]
        |=> s_q.inv[0] == $past(s_q.inv[0]))
        else $error("invert changed on unselected channel");
    drive_local_a: assert property (
        wr_en && addr == OUT_ADJUST_ADDR && sel[1]
        |=> drive_x2_out[1] == $past(wr_data[DRIVE_X2_BIT]))
        else $error("drive bit not written on selected channel");
    shared_all_a: assert property (
        wr_en && addr == OUT_ADJUST_ADDR
        |=> adjust_shared_out == ($past(wr_data) & ADJUST_SHARED_MASK))
        else $error("shared adjust bits not applied");
    phase_range_a: assert property (s_q.phase <= PHASE_MAX)
        else $error("phase code out of range");
    phase_reject_a: assert property (
        wr_en && addr == OUT_PHASE_ADDR && wr_data[PHASE_W-1:0] > PHASE_MAX
        |=> $stable(s_q.phase))
        else $error("invalid phase code accepted");
    phase_accept_a: assert property (
        wr_en && addr == OUT_PHASE_ADDR
        && wr_data[PHASE_W-1:0] <= PHASE_MAX
        |=> s_q.phase == $past(wr_data[PHASE_W-1:0]))
        else $error("valid phase code not stored");
    frame_fixed_a: assert property (
        ##1 serial_frame_clock_out == $past(frame_clk_in))
        else $error("frame clock timing moved");
    phase_select_a: assert property (
        ##1 serial_bit_clock_out == $past(divider_phase_in[s_q.phase]))
        else $error("bit clock not from selected phase");
    latch_fixed_a: assert property (
        !sample_valid_in |=> $stable(sample_out))
        else $error("samples moved without strobe");
    reset_phase_a: assert property (
        $rose(arst_n_in) |-> s_q.phase == PHASE_RST)
        else $error("phase reset value wrong");

    write_phase_c: cover property (wr_en && addr == OUT_PHASE_ADDR);
    write_format_c: cover property (wr_en && addr == OUT_FORMAT_ADDR);
    read_back_c: cover property (sdio_oe_out);
    twos_sample_c: cover property (
        sample_valid_in && s_q.fmt[1:0] == FMT_TWOS);
endmodule : serial_output_config_regs

// ### test/link_receiver.sv
module link_receiver
    import serial_output_pkg::*;
(
    // clock and reset
    input  wire logic                            core_clk_in,
    input  wire logic                            arst_n_in,
    // serial link lanes
    input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0] lanes_in,
    // captured view
    output logic [NUM_CH-1:0][SAMPLE_W-1:0]      word_out
);
    // receiver registers every lane word it is handed
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            word_out <= '0;
        end else begin
            word_out <= lanes_in;
        end
    end
endmodule : link_receiver

// ### test/tb.sv
module tb
    import serial_output_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                            core_clk_in = 1'b0;
    logic                            arst_n_in = 1'b0;
    logic                            csb_n_in = 1'b1;
    logic                            sclk_in = 1'b0;
    logic                            sdio_drv = 1'b0;
    logic                            sdio_in, sdio_out, sdio_oe_out;
    logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_in = '0;
    logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_out, rx_word;
    logic                            sample_valid_in = 1'b0;
    logic [NUM_PHASES-1:0]           divider_phase_in = '0;
    logic                            bit_clk;
    logic                            frame_clk = 1'b0;
    logic                            fclk;
    logic [NUM_CH-1:0]               drive_x2_out;
    logic [7:0]                      format_shared_out, adjust_shared_out;
    int                              fails = 0;
    int                              comparisons = 0;

    always #4 core_clk_in = ~core_clk_in;
    // shared data wire: device wins while it drives
    assign sdio_in = sdio_oe_out ? sdio_out : sdio_drv;

    serial_output_config_regs DUT (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .csb_n_in(csb_n_in), .sclk_in(sclk_in), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out),
        .sample_in(sample_in), .sample_valid_in(sample_valid_in),
        .divider_phase_in(divider_phase_in), .frame_clk_in(frame_clk),
        .sample_out(sample_out), .serial_bit_clock_out(bit_clk),
        .serial_frame_clock_out(fclk), .drive_x2_out(drive_x2_out),
        .format_shared_out(format_shared_out),
        .adjust_shared_out(adjust_shared_out));
    link_receiver rx (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .lanes_in(sample_out), .word_out(rx_word));

    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // one 24-bit control frame, each sclk level held 3 core cycles
    task automatic frame(input logic rw, input logic [14:0] a,
                         input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] bits;
        bits = {rw, a, wd};
        rd = 8'h00;
        csb_n_in = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk_in = 1'b0;
            sdio_drv = bits[i];
            repeat (3) @(negedge core_clk_in);
            if (i < 8) rd[i] = sdio_in;
            sclk_in = 1'b1;
            repeat (3) @(negedge core_clk_in);
        end
        sclk_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        csb_n_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
    endtask : frame

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] unused;
        frame(1'b0, a, d, unused);
    endtask : wr

    task automatic rd_chk(input string n, input logic [14:0] a,
                          input logic [7:0] e);
        logic [7:0] v;
        frame(1'b1, a, 8'h00, v);
        chk(n, v, e);
    endtask : rd_chk

    function automatic logic [11:0] enc(logic [11:0] v, logic tw, iv);
        logic [11:0] r;
        r = tw ? v ^ 12'h800 : v;
        return iv ? ~r : r;
    endfunction : enc

    task automatic samp_chk(input logic [7:0] inv, input logic tw);
        for (int k = 0; k < NUM_CH; k++) sample_in[k] = {4'(k), 8'hC3};
        sample_valid_in = 1'b1;
        @(negedge core_clk_in);
        sample_valid_in = 1'b0;
        for (int k = 0; k < NUM_CH; k++)
            chk("sample_out", sample_out[k],
                enc(sample_in[k], tw, inv[k]));
        @(negedge core_clk_in);
        for (int k = 0; k < NUM_CH; k++)
            chk("rx_word", rx_word[k],
                enc(sample_in[k], tw, inv[k]));
    endtask : samp_chk

    task automatic reset_chk;
        divider_phase_in = NUM_PHASES'(8);
        repeat (2) @(negedge core_clk_in);
        chk("bit_clk_reset", bit_clk, 1'b1);
        rd_chk("format_reset", OUT_FORMAT_ADDR, 8'h00);
        rd_chk("adjust_reset", OUT_ADJUST_ADDR, 8'h00);
        rd_chk("phase_reset", OUT_PHASE_ADDR, 8'h03);
        rd_chk("unmapped", 15'h0030, 8'h00);
        samp_chk(8'h00, 1'b0);
    endtask : reset_chk

    task automatic phase_scan;
        for (int c = 0; c <= 10; c++) begin
            wr(OUT_PHASE_ADDR, 8'(c));
            rd_chk("phase", OUT_PHASE_ADDR, 8'(c));
            divider_phase_in = NUM_PHASES'(1) << c;
            frame_clk = 1'b1;
            repeat (2) @(negedge core_clk_in);
            chk("bit_clk_hi", bit_clk, 1'b1);
            chk("frame_clk_hi", fclk, 1'b1);
            divider_phase_in = ~(NUM_PHASES'(1) << c);
            frame_clk = 1'b0;
            repeat (2) @(negedge core_clk_in);
            chk("bit_clk_lo", bit_clk, 1'b0);
            chk("frame_clk_lo", fclk, 1'b0);
        end
        wr(OUT_PHASE_ADDR, 8'h0B);
        rd_chk("phase_bad", OUT_PHASE_ADDR, 8'h0A);
        wr(OUT_PHASE_ADDR, 8'h0F);
        rd_chk("phase_bad", OUT_PHASE_ADDR, 8'h0A);
        samp_chk(8'h00, 1'b0);
    endtask : phase_scan

    task automatic format_chk;
        wr(OUT_FORMAT_ADDR, 8'h01);
        samp_chk(8'h00, 1'b1);
        wr(CH_SELECT_ADDR, 8'h01);
        wr(OUT_FORMAT_ADDR, 8'hFD);
        chk("fmt_shared", format_shared_out, 8'hF9);
        samp_chk(8'h01, 1'b1);
        wr(CH_SELECT_ADDR, 8'h02);
        wr(OUT_FORMAT_ADDR, 8'h00);
        chk("fmt_shared", format_shared_out, 8'h00);
        samp_chk(8'h01, 1'b0);
        wr(CH_SELECT_ADDR, 8'h01);
        rd_chk("fmt_ch0", OUT_FORMAT_ADDR, 8'h04);
    endtask : format_chk

    task automatic adjust_chk;
        wr(CH_SELECT_ADDR, 8'h80);
        wr(OUT_ADJUST_ADDR, 8'hAB);
        chk("adj_shared", adjust_shared_out, 8'hAA);
        chk("drive_x2", drive_x2_out, 8'h80);
        rd_chk("adj_read", OUT_ADJUST_ADDR, 8'hAB);
        wr(CH_SELECT_ADDR, 8'hFF);
        wr(OUT_ADJUST_ADDR, 8'h00);
        chk("drive_x2", drive_x2_out, 8'h00);
        chk("adj_shared", adjust_shared_out, 8'h00);
    endtask : adjust_chk

    initial begin
        repeat (10) @(negedge core_clk_in);
        arst_n_in = 1'b1;
        @(negedge core_clk_in);
        reset_chk();
        phase_scan();
        format_chk();
        adjust_chk();
        tally_and_finish();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge core_clk_in);
        fails++;
        tally_and_finish();
    end
endmodule : tb
